/* File: fsb_params.svh */
`ifndef FSB_PARAMS_SVH
`define FSB_PARAMS_SVH

// ==========================================================================
// Register map (byte addresses on the Avalon-MM slave)
`define FSB_OFS_OE_CTRL    8'h00
`define FSB_OFS_STATE      8'h04
`define FSB_OFS_IRQ_STAT   8'h08
`define FSB_OFS_IRQ_MASK   8'h0c

// ==========================================================================
// Reset values
`define FSB_RST_OE_CTRL    16'hffff
`define FSB_RST_SB_CTRL    16'hffff
`define FSB_RST_IRQ_MASK   4'h0

// ==========================================================================
// Field positions
`define FSB_ST_SB_MODE     0
`define FSB_ST_RUNNING     1
`define FSB_ST_PWR_DOWN    2
`define FSB_ST_REF_LOST    3
`define FSB_ST_FAST_SLEW   4
`define FSB_ST_ADDR_LSB    8
`define FSB_ST_SBCTL_LSB   16
`define FSB_EV_REF_LOST    0
`define FSB_EV_REF_BACK    1
`define FSB_EV_SB_LOAD     2
`define FSB_EV_PWR_DOWN    3

// ==========================================================================
// Sizes and timing
`define FSB_N_OUT          16
`define FSB_N_EV           4
`define FSB_CLK_PERIOD_NS  8
`define FSB_REF_LOSS_NS    200
`define FSB_REF_LOSS_CYC   ((`FSB_REF_LOSS_NS + `FSB_CLK_PERIOD_NS - 1) / `FSB_CLK_PERIOD_NS)

`endif

/* File: fsb_pkg.sv */
package fsb_pkg;

  // ========================================================================
  // Start-up and power state
  typedef enum logic [1:0] {
    FSB_WAIT_PG,
    FSB_RUN,
    FSB_PDN
  } fsb_state_e;

  // ========================================================================
  // All pins that arrive from outside the clock domain, synchronised as one
  typedef struct packed {
    logic [15:0] out_en_n;
    logic        strap;
    logic        power_good;
    logic        ref_level;
    logic        edge_speed;
    logic [1:0]  addr_a;
    logic [1:0]  addr_b;
  } fsb_pins_s;

endpackage : fsb_pkg

/* File: fsb_ctrl.sv */
`timescale 1ns/10ps
`include "fsb_params.svh"

module fsb_ctrl
  import fsb_pkg::*;
#(
  parameter int SB_LEN     = 16,
  parameter bit VARIANT_16 = 1'b1
) (
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  SRST,
  // Avalon-MM register slave
  input  wire logic [7:0]            AVS_ADDRESS,
  input  wire logic                  AVS_READ,
  input  wire logic                  AVS_WRITE,
  input  wire logic [31:0]           AVS_WRITEDATA,
  input  wire logic [3:0]            AVS_BYTEENABLE,
  output logic      [31:0]           AVS_READDATA,
  output logic                       AVS_WAITREQUEST,
  output logic                       IRQ,
  // Enable pins, straps and sequencing inputs
  input  wire logic [`FSB_N_OUT-1:0] OUT_EN_N,
  input  wire logic                  SIDEBAND_SELECT_STRAP,
  input  wire logic                  POWER_GOOD_OR_DOWN_N,
  input  wire logic                  REF_IN_P,
  input  wire logic                  REF_IN_N,
  input  wire logic                  EDGE_SPEED_SELECT,
  input  wire logic [1:0]            BUS_ADDR_STRAP_A,
  input  wire logic [1:0]            BUS_ADDR_STRAP_B,
  // Control outputs toward the clock path
  output logic      [`FSB_N_OUT-1:0] FANOUT_EN,
  output logic                       FAST_SLEW,
  output logic      [3:0]            BUS_ADDR_SEL,
  output logic                       POWER_DOWN,
  // Open-drain loss indicator and serial data out on the output-2 pin
  output logic                       REF_ABSENT_N_O,
  output logic                       REF_ABSENT_N_OE,
  output logic                       SERIAL_OUT_O,
  output logic                       SERIAL_OUT_OE
);

  // ========================================================================
  // Pin synchronisers
  fsb_pins_s pin_raw;
  fsb_pins_s pin_s1;
  fsb_pins_s pin_s2;
  fsb_pins_s pin_s3;

  // Bundle the pins; the reference is seen as the sign of its pair
  assign pin_raw.out_en_n   = OUT_EN_N;
  assign pin_raw.strap      = SIDEBAND_SELECT_STRAP;
  assign pin_raw.power_good = POWER_GOOD_OR_DOWN_N;
  assign pin_raw.ref_level  = REF_IN_P & ~REF_IN_N;
  assign pin_raw.edge_speed = EDGE_SPEED_SELECT;
  assign pin_raw.addr_a     = BUS_ADDR_STRAP_A;
  assign pin_raw.addr_b     = BUS_ADDR_STRAP_B;

  // Two stages, plus a third kept only for edge detection on stage two
  always_ff @(posedge CLK) begin
    pin_s1 <= pin_raw;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
  end

  // ========================================================================
  // Start-up and power-down sequencing
  fsb_state_e state;
  fsb_state_e next_state;
  logic       sb_mode;
  logic       slew_latch;
  logic [1:0] addr_a_latch;
  logic [1:0] addr_b_latch;
  wire        pg       = pin_s2.power_good;
  wire        start_up = (state == FSB_WAIT_PG) && pg;
  wire        running  = (state == FSB_RUN);

  // First high power-good starts us; later lows and highs toggle power-down
  always_comb begin
    next_state = state;
    case (state)
      FSB_WAIT_PG: if (pg) next_state = FSB_RUN;
      FSB_RUN:     if (!pg) next_state = FSB_PDN;
      FSB_PDN:     if (pg) next_state = FSB_RUN;
      default:     next_state = FSB_WAIT_PG;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) state <= FSB_WAIT_PG;
    else      state <= next_state;
  end

  // Straps are caught once; the strap is trusted to stay put afterwards
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sb_mode      <= 1'b0;
      slew_latch   <= 1'b0;
      addr_a_latch <= 2'h0;
      addr_b_latch <= 2'h0;
    end else if (start_up) begin
      sb_mode      <= pin_s2.strap;
      slew_latch   <= pin_s2.edge_speed;
      addr_a_latch <= pin_s2.addr_a;
      addr_b_latch <= pin_s2.addr_b;
    end
  end

  // ========================================================================
  // Tri-level address decode: low, mid, high per strap, nine addresses
  wire [3:0] addr_a_val = (addr_a_latch == 2'h0) ? 4'h0 : (addr_a_latch == 2'h1) ? 4'h1 : 4'h2;
  wire [3:0] addr_b_val = (addr_b_latch == 2'h0) ? 4'h0 : (addr_b_latch == 2'h1) ? 4'h1 : 4'h2;
  wire [3:0] addr_sel   = 4'((addr_a_val << 1) + addr_a_val + addr_b_val);

  // ========================================================================
  // Side-band serial port
  localparam logic [`FSB_N_OUT-1:0] MUX_MASK16 = 16'h2224;
  localparam logic [`FSB_N_OUT-1:0] MUX_MASK13 = 16'h2244;
  // Shared enable pins differ between the two package variants
  wire [`FSB_N_OUT-1:0] mux_mask   = VARIANT_16 ? MUX_MASK16 : MUX_MASK13;
  wire                  sclk_now   = VARIANT_16 ? pin_s2.out_en_n[5] : pin_s2.out_en_n[6];
  wire                  sclk_prev  = VARIANT_16 ? pin_s3.out_en_n[5] : pin_s3.out_en_n[6];
  wire                  sdi        = pin_s2.out_en_n[9];
  wire                  ld_lvl     = pin_s2.out_en_n[13];
  wire                  sclk_rise  = sb_mode && sclk_now && !sclk_prev;
  wire                  ld_fall    = sb_mode && !ld_lvl && pin_s3.out_en_n[13];
  wire                  shift_now  = sclk_rise && ld_lvl;

  logic [SB_LEN-1:0]     shreg;
  logic [`FSB_N_OUT-1:0] sb_ctrl;

  // Shift on a sampled clock edge; the link clock is slow against CLK
  always_ff @(posedge CLK) begin
    if (SRST)           shreg <= '0;
    else if (shift_now) shreg <= {shreg[SB_LEN-2:0], sdi};
  end

  // Falling load edge commits the whole shift register at once
  always_ff @(posedge CLK) begin
    if (SRST)         sb_ctrl <= `FSB_RST_SB_CTRL;
    else if (ld_fall) sb_ctrl <= `FSB_N_OUT'(shreg);
  end

  // Serial out drives the pin only in side-band mode, else it is an input
  always_ff @(posedge CLK) begin
    if (SRST) begin
      SERIAL_OUT_O  <= 1'b0;
      SERIAL_OUT_OE <= 1'b0;
    end else begin
      SERIAL_OUT_O  <= shreg[SB_LEN-1];
      SERIAL_OUT_OE <= sb_mode;
    end
  end

  // ========================================================================
  // Reference loss detector: no edge within the window means lost
  localparam int LOSS_CYC = `FSB_REF_LOSS_CYC;
  logic [7:0] ref_idle;
  logic       ref_lost;
  wire        ref_edge = pin_s2.ref_level ^ pin_s3.ref_level;
  wire        ref_lost_next = (ref_idle >= 8'(LOSS_CYC - 1)) && !ref_edge;

  // Saturating idle counter avoids wrap-around false recovery
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ref_idle <= 8'h0;
      ref_lost <= 1'b0;
    end else begin
      ref_idle <= ref_edge ? 8'h0 : (ref_lost_next ? ref_idle : ref_idle + 8'h1);
      ref_lost <= ref_lost_next;
    end
  end

  // ========================================================================
  // Avalon-MM slave: one wait cycle, then the answer
  logic [`FSB_N_OUT-1:0] oe_ctrl;
  logic [`FSB_N_EV-1:0]  irq_stat;
  logic [`FSB_N_EV-1:0]  irq_mask;
  wire                   req    = AVS_READ | AVS_WRITE;
  wire                   acc    = req & ~AVS_WAITREQUEST;
  wire                   wr_acc = acc & AVS_WRITE;
  wire [31:0]            wmask  = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                                   {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  wire [31:0]            wbits  = AVS_WRITEDATA & wmask;
  wire                   hit_oe = (AVS_ADDRESS == `FSB_OFS_OE_CTRL);
  wire                   hit_st = (AVS_ADDRESS == `FSB_OFS_STATE);
  wire                   hit_is = (AVS_ADDRESS == `FSB_OFS_IRQ_STAT);
  wire                   hit_im = (AVS_ADDRESS == `FSB_OFS_IRQ_MASK);

  // State word shows the block's own status and the latched side-band word
  wire [31:0] state_word = {sb_ctrl, 4'h0, addr_sel, 3'h0, slew_latch, ref_lost,
                            (state == FSB_PDN), running, sb_mode};
  // Unmapped addresses read as zero and ignore writes
  wire [31:0] rd_mux = hit_oe ? {16'h0, oe_ctrl} :
                       hit_st ? state_word :
                       hit_is ? {28'h0, irq_stat} :
                       hit_im ? {28'h0, irq_mask} : 32'h0;

  // Waitrequest idles high and drops for exactly one cycle per request
  always_ff @(posedge CLK) begin
    if (SRST) AVS_WAITREQUEST <= 1'b1;
    else      AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);
  end

  // Read data is captured in the wait cycle and holds afterwards
  always_ff @(posedge CLK) begin
    if (SRST)                             AVS_READDATA <= 32'h0;
    else if (AVS_READ && AVS_WAITREQUEST) AVS_READDATA <= rd_mux;
  end

  // Software output enables, one per output, 1 keeps the output on
  always_ff @(posedge CLK) begin
    if (SRST)                oe_ctrl <= `FSB_RST_OE_CTRL;
    else if (wr_acc && hit_oe) oe_ctrl <= (oe_ctrl & ~wmask[15:0]) | wbits[15:0];
  end

  always_ff @(posedge CLK) begin
    if (SRST)                irq_mask <= `FSB_RST_IRQ_MASK;
    else if (wr_acc && hit_im) irq_mask <= (irq_mask & ~wmask[3:0]) | wbits[3:0];
  end

  // ========================================================================
  // Interrupts: sticky events, write one to clear, a new event wins
  wire [`FSB_N_EV-1:0] events;
  wire [`FSB_N_EV-1:0] clr = (wr_acc && hit_is) ? wbits[3:0] : 4'h0;

  assign events[`FSB_EV_REF_LOST] = ref_lost_next & ~ref_lost;
  assign events[`FSB_EV_REF_BACK] = ~ref_lost_next & ref_lost;
  assign events[`FSB_EV_SB_LOAD]  = ld_fall;
  assign events[`FSB_EV_PWR_DOWN] = running && !pg;

  always_ff @(posedge CLK) begin
    if (SRST) irq_stat <= 4'h0;
    else      irq_stat <= events | (irq_stat & ~clr);
  end

  always_ff @(posedge CLK) begin
    if (SRST) IRQ <= 1'b0;
    else      IRQ <= |((events | (irq_stat & ~clr)) & irq_mask);
  end

  // ========================================================================
  // Output enables: pin or side-band word, and the software bit, when running
  wire [`FSB_N_OUT-1:0] pin_en  = ~pin_s2.out_en_n;
  wire [`FSB_N_OUT-1:0] sel_en  = sb_mode ? ((pin_en & ~mux_mask) | (sb_ctrl & mux_mask))
                                          : pin_en;
  wire [`FSB_N_OUT-1:0] next_en = (running && pg) ? (sel_en & oe_ctrl)
                                                  : '0;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      FANOUT_EN       <= '0;
      FAST_SLEW       <= 1'b0;
      BUS_ADDR_SEL    <= 4'h0;
      POWER_DOWN      <= 1'b1;
      REF_ABSENT_N_O  <= 1'b0;
      REF_ABSENT_N_OE <= 1'b0;
    end else begin
      FANOUT_EN       <= next_en;
      FAST_SLEW       <= slew_latch;
      BUS_ADDR_SEL    <= addr_sel;
      POWER_DOWN      <= !(running && pg);
      REF_ABSENT_N_O  <= 1'b0;
      REF_ABSENT_N_OE <= ref_lost;
    end
  end

  // ========================================================================
  // Assertions
  property p_pin_low_enables;
    @(posedge CLK) disable iff (SRST)
      (running && pg && oe_ctrl[0] && !pin_s2.out_en_n[0]) |=> FANOUT_EN[0];
  endproperty
  a_pin_low_enables: assert property (p_pin_low_enables) else $error("enable pin low ignored");

  property p_strap_off_no_drive;
    @(posedge CLK) disable iff (SRST) !sb_mode |=> !SERIAL_OUT_OE;
  endproperty
  a_strap_off_no_drive: assert property (p_strap_off_no_drive) else $error("serial pin driven");

  property p_unshared_kept;
    @(posedge CLK) disable iff (SRST)
      (sb_mode && running && pg && !oe_ctrl[0]) |=> !FANOUT_EN[0];
  endproperty
  a_unshared_kept: assert property (p_unshared_kept) else $error("software enable ignored");

  property p_shift_gated;
    @(posedge CLK) disable iff (SRST) (sb_mode && !ld_lvl) |=> $stable(shreg);
  endproperty
  a_shift_gated: assert property (p_shift_gated) else $error("shift while load low");

  property p_load_copy;
    @(posedge CLK) disable iff (SRST) ld_fall |=> (sb_ctrl == `FSB_N_OUT'($past(shreg)));
  endproperty
  a_load_copy: assert property (p_load_copy) else $error("load did not copy");

  property p_shift_in;
    @(posedge CLK) disable iff (SRST)
      shift_now |=> (shreg[0] == $past(sdi)) && (shreg[SB_LEN-1:1] == $past(shreg[SB_LEN-2:0]));
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift wrong");

  property p_serial_out;
    @(posedge CLK) disable iff (SRST)
      sb_mode ##1 sb_mode |-> SERIAL_OUT_OE && (SERIAL_OUT_O == $past(shreg[SB_LEN-1]));
  endproperty
  a_serial_out: assert property (p_serial_out) else $error("serial out wrong");

  property p_start_latch;
    @(posedge CLK) disable iff (SRST)
      start_up |=> running && (sb_mode == $past(pin_s2.strap)) ##1 !POWER_DOWN || !pg;
  endproperty
  a_start_latch: assert property (p_start_latch) else $error("start-up wrong");

  property p_power_down;
    @(posedge CLK) disable iff (SRST)
      (running && !pg) |=> (state == FSB_PDN) && POWER_DOWN && (FANOUT_EN == '0);
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down missed");

  property p_ref_loss;
    @(posedge CLK) disable iff (SRST) ref_lost |=> REF_ABSENT_N_OE && !REF_ABSENT_N_O;
  endproperty
  a_ref_loss: assert property (p_ref_loss) else $error("loss indicator not low");

  property p_slew;
    @(posedge CLK) disable iff (SRST) start_up |=> ##1 (FAST_SLEW == $past(pin_s2.edge_speed, 2));
  endproperty
  a_slew: assert property (p_slew) else $error("slew select wrong");

  property p_sb_enable;
    @(posedge CLK) disable iff (SRST)
      (sb_mode && running && pg && oe_ctrl[9]) |=> (FANOUT_EN[9] == $past(sb_ctrl[9]));
  endproperty
  a_sb_enable: assert property (p_sb_enable) else $error("side-band enable ignored");

  property p_pin_high_disables;
    @(posedge CLK) disable iff (SRST) (!sb_mode && pin_s2.out_en_n[3]) |=> !FANOUT_EN[3];
  endproperty
  a_pin_high_disables: assert property (p_pin_high_disables) else $error("pin high ignored");

  property p_no_shift_off;
    @(posedge CLK) disable iff (SRST) !sb_mode |=> $stable(shreg) && $stable(sb_ctrl);
  endproperty
  a_no_shift_off: assert property (p_no_shift_off) else $error("side-band active while off");

  property p_ref_release;
    @(posedge CLK) disable iff (SRST) !ref_lost |=> !REF_ABSENT_N_OE;
  endproperty
  a_ref_release: assert property (p_ref_release) else $error("loss indicator stuck low");

  property p_addr_range;
    @(posedge CLK) disable iff (SRST) running |-> (BUS_ADDR_SEL <= 4'h8);
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("bus address out of range");

endmodule : fsb_ctrl

/* File: fsb_board.sv */
`timescale 1ns/10ps
// ==========================================================================
// Board controller: holds the enable pins and plays the side-band link
module fsb_board (
  // Board enable levels and mode
  input  wire logic [15:0] PINS,
  input  wire logic        SB_ON,
  // Output-2 pin as the buffer drives it
  input  wire logic        SO_O,
  input  wire logic        SO_OE,
  // Resolved pin levels and the word read back down the chain
  output logic      [15:0] EN_N,
  output logic      [15:0] SO_WORD
);
  logic sclk = 1'b0;
  logic sdat = 1'b0;
  logic sld  = 1'b0;

  // Shared pins follow the link in side-band mode; released pin 2 sits on its pull-up
  always_comb begin
    EN_N = PINS;
    if (SB_ON) begin
      EN_N[5]  = sclk;
      EN_N[9]  = sdat;
      EN_N[13] = sld;
    end
    EN_N[2] = SO_OE ? SO_O : (SB_ON ? 1'b1 : PINS[2]);
  end

  // One frame, top bit first; the link clock stands low outside frames
  task automatic send(input logic [15:0] w, input logic ld);
    #3;
    sld = ld;  // Moved off the system clock edge to avoid a sampling race
    #16;
    for (int i = 15; i >= 0; i--) begin
      sdat = w[i];
      #32;
      SO_WORD[i] = EN_N[2];  // Chained bit is read just before the rise
      sclk = 1'b1;
      #32;
      sclk = 1'b0;
    end
    #16;
    sld = 1'b0;  // Falling load edge commits the word
    #40;
  endtask : send
endmodule : fsb_board

/* File: tb.sv */
`timescale 1ns/10ps
// ==========================================================================
// Self-checking bench for the fanout enable and side-band controller
module tb;
  import fsb_pkg::*;
  localparam logic [15:0] SHM = 16'h2224;  // Shared outputs 13, 9, 5, 2
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, q;
  logic        wait_r, irq, fast, pdn, ra_o, ra_oe, so_o, so_oe;
  logic [15:0] pins = 16'hffff;
  logic [15:0] en_n, fan_en, so_word, oe, w1, w2;
  logic        strap = 1'b0;
  logic        pg = 1'b0;
  logic        refp = 1'b0;
  logic        ref_run = 1'b1;
  logic        sb_on = 1'b0;
  logic        slew = 1'b1;
  logic [1:0]  adr_a = 2'b01;
  logic [1:0]  adr_b = 2'b10;
  logic [3:0]  bsel;
  int          err_count = 0;
  int          compares = 0;
  int          cycles = 0;
  int          seed = 32'h4714;

  // ========================================================================
  // Clocks: system at 8 ns, reference at 40 ns, every reference edge landing on a system clock edge
  initial begin
    forever #4 clk = ~clk;
  end
  always #20 if (ref_run) refp = ~refp;

  fsb_ctrl #(.SB_LEN(16), .VARIANT_16(1'b1)) i_fsb_ctrl (
    .CLK(clk), .SRST(srst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_r), .IRQ(irq), .OUT_EN_N(en_n),
    .SIDEBAND_SELECT_STRAP(strap), .POWER_GOOD_OR_DOWN_N(pg), .REF_IN_P(refp),
    .REF_IN_N(~refp), .EDGE_SPEED_SELECT(slew), .BUS_ADDR_STRAP_A(adr_a),
    .BUS_ADDR_STRAP_B(adr_b), .FANOUT_EN(fan_en), .FAST_SLEW(fast),
    .BUS_ADDR_SEL(bsel), .POWER_DOWN(pdn), .REF_ABSENT_N_O(ra_o),
    .REF_ABSENT_N_OE(ra_oe), .SERIAL_OUT_O(so_o), .SERIAL_OUT_OE(so_oe));
  fsb_board i_fsb_board (
    .PINS(pins), .SB_ON(sb_on), .SO_O(so_o), .SO_OE(so_oe), .EN_N(en_n),
    .SO_WORD(so_word));

  // ========================================================================
  // Checking and bus helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low, data taken at that edge
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_r !== 1'b0 && n < 50);
    if (n >= 50) chk(1, 0, "bus answer");
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : av
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Enable each output ought to show, from pins, software bits and side-band word
  function automatic logic [15:0] exp_en(input logic [15:0] p, input logic [15:0] o,
                                         input logic [15:0] w, input logic sbm);
    return (sbm ? ((w & SHM) | (~p & ~SHM)) : ~p) & o;
  endfunction : exp_en
  task automatic report_and_stop;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // A hang ends the run through the same report
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  // ========================================================================
  // Main sequence
  initial begin
    cyc(5);
    srst <= 1'b0;
    cyc(3);
    chk(pdn, 1, "pdn before start");
    chk(fan_en, 0, "off before start");
    av(0, 8'h00, 0); chk(q, 32'hffff, "oe reset");
    av(0, 8'h0c, 0); chk(q, 0, "mask reset");
    av(0, 8'h10, 0); chk(q, 0, "unmapped read");
    av(1, 8'h10, 32'h1234);
    av(0, 8'h04, 0); chk(q[1], 0, "not running");
    pg <= 1'b1;
    cyc(8);
    chk(pdn, 0, "started");
    chk(fast, 1, "fast slew");
    chk(bsel, 5, "bus address");
    // Enable pins and software bits, corners first, then random
    for (int i = 0; i < 10; i++) begin
      pins <= (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($random(seed));
      oe = (i < 2) ? 16'hffff : 16'($random(seed));
      av(1, 8'h00, {16'h0, oe});
      cyc(6);
      chk(fan_en, exp_en(pins, oe, 0, 0), "oe mode enables");
    end
    // Power-down and exit
    av(1, 8'h08, 32'hf);
    pg <= 1'b0;
    cyc(6);
    chk({pdn, fan_en}, {1'b1, 16'h0}, "power down");
    av(0, 8'h08, 0); chk(q[3], 1, "pdn event");
    pg <= 1'b1;
    cyc(6);
    chk({pdn, fan_en}, {1'b0, exp_en(pins, oe, 0, 0)}, "power back");
    // Reference loss, masked and unmasked events
    av(1, 8'h08, 32'hf);
    av(1, 8'h0c, 32'h1);
    ref_run <= 1'b0;
    cyc(40);
    chk({ra_oe, ra_o, irq}, 3'b101, "ref lost");
    av(1, 8'h08, 32'h1);
    cyc(2);
    chk(irq, 0, "irq cleared");
    ref_run <= 1'b1;
    cyc(10);
    chk({ra_oe, irq}, 2'b00, "ref back");
    av(0, 8'h08, 0); chk(q[1:0], 2'b10, "ref back event");
    // Side-band mode: strap moves only while held in reset
    srst <= 1'b1;
    pg <= 1'b0;
    strap <= 1'b1;
    slew <= 1'b0;
    adr_a <= 2'b11;
    adr_b <= 2'b00;
    cyc(3);
    srst <= 1'b0;
    sb_on <= 1'b1;
    pins <= 16'($random(seed));
    cyc(4);
    pg <= 1'b1;
    cyc(8);
    chk(so_oe, 1, "serial out driven");
    chk(fast, 0, "slow slew");
    chk(bsel, 6, "bus address 2");
    oe = 16'($random(seed)) | SHM;
    av(1, 8'h00, {16'h0, oe});
    w1 = 16'($random(seed));
    i_fsb_board.send(w1, 1'b1);
    cyc(4);
    av(0, 8'h04, 0); chk(q[31:16], w1, "word loaded");
    chk(q[11:0], 12'h603, "state bits");
    chk(fan_en, exp_en(pins, oe, w1, 1), "sb enables");
    av(0, 8'h08, 0); chk(q[2], 1, "load event");
    i_fsb_board.send(~w1, 1'b0);
    cyc(4);
    av(0, 8'h04, 0); chk(q[31:16], w1, "load low holds");
    w2 = 16'($random(seed));
    i_fsb_board.send(w2, 1'b1);
    cyc(4);
    chk(so_word, w1, "chained bits");
    av(0, 8'h04, 0); chk(q[31:16], w2, "second word");
    chk(fan_en, exp_en(pins, oe, w2, 1), "sb enables 2");
    report_and_stop();
  end
endmodule : tb
